// File: verilog/uie_pkg.sv
// Constants shared by the device interrupt enable block
package uie_pkg;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    localparam logic [11:0] OFS_ENABLE = 12'h214;
    localparam logic [11:0] OFS_PENDING = 12'h2f0;

    // ------------------------------------------------------------
    // Reset values and writable bits
    // ------------------------------------------------------------
    localparam logic [31:0] ENABLE_RST = 32'h0000_0001;
    localparam logic [31:0] PENDING_RST = 32'h0000_0000;
    localparam logic [31:0] WRITE_MASK = 32'h03ff_fdff;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_EP_LO = 12;
    localparam int BIT_EP_HI = 25;
    localparam int NUM_DATA_EP = 7;
    localparam int BIT_CTRL_IN = 11;
    localparam int BIT_CTRL_OUT = 10;
    localparam int BIT_RSVD = 9;
    localparam int BIT_SETUP = 8;
    localparam int BIT_VBUS = 7;
    localparam int BIT_DMA = 6;
    localparam int BIT_SPEED = 5;
    localparam int BIT_RESUME = 4;
    localparam int BIT_SUSPEND = 3;
    localparam int BIT_PSOF = 2;
    localparam int BIT_SOF = 1;
    localparam int BIT_BRST = 0;
    localparam int NUM_SRC = 26;

endpackage

// File: verilog/uie_sync.sv
// Two-stage synchroniser for a level arriving from a pin
`timescale 1ns/1ps

module uie_sync (
    input wire logic clock, // Controller clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic d, // Asynchronous level
    output logic q // Synchronised level
);

    logic meta_ff;
    logic q_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= 1'b0;
            q_ff <= 1'b0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;

endmodule

// File: verilog/uie_sticky.sv
// One sticky pending flag: an event sets it, a read clears it
`timescale 1ns/1ps

module uie_sticky (
    input wire logic clock, // Controller clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic set, // Event pulse
    input wire logic clr, // Clear pulse from a status read
    output logic q // Pending flag
);

    logic q_ff;
    logic nxt_q;

    // Set wins so an event in the clearing cycle is kept
    always_comb begin
        nxt_q = q_ff;
        if (clr) begin
            nxt_q = 1'b0;
        end
        if (set) begin
            nxt_q = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            q_ff <= 1'b0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q = q_ff;

endmodule

// File: verilog/uie_top.sv
// Device controller interrupt enable register with pending flags and request output
// Notes on behaviour
// - Endpoints 1-7 tx/rx enables, bits 12-25.
// - Bit 11 gates control IN interrupts.
// - Bit 10 gates control OUT interrupts.
// - Bit 8 gates setup-received interrupt.
// - Bit 7 gates bus supply sense interrupt.
// - Bit 6 gates DMA status change interrupt.
// - Bit 5 gates speed status change interrupt.
// - Bit 4 gates resume interrupt.
// - Bit 3 gates suspend interrupt.
// - Bit 2 gates pseudo frame start interrupt.
// - Bit 0 gates bus reset, resets to one.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps

module uie_top
    import uie_pkg::*;
(
    input wire logic clock, // Controller clock, 50 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic [11:0] addr, // Register byte address
    input wire logic [31:0] wdata, // Write data
    input wire logic wr_stb, // Write strobe, one cycle
    input wire logic rd_stb, // Read strobe, one cycle
    input wire logic [6:0] ep_tx_evt, // Data endpoint 1..7 transmit events
    input wire logic [6:0] ep_rx_evt, // Data endpoint 1..7 receive events
    input wire logic ctrl_in_evt, // Control IN buffer event
    input wire logic ctrl_out_evt, // Control OUT buffer event
    input wire logic ctrl_setup_evt, // Setup data received
    input wire logic bus_supply_pin, // Bus supply sense level, asynchronous
    input wire logic dma_change_evt, // DMA status changed
    input wire logic speed_change_evt, // High-speed status changed
    input wire logic resume_evt, // Resume detected
    input wire logic suspend_evt, // Suspend detected
    input wire logic pseudo_frame_evt, // Pseudo frame start
    input wire logic frame_start_evt, // Frame start packet received
    input wire logic bus_reset_evt, // Bus reset detected
    output logic [31:0] rd_data_ff, // Read data, valid the cycle after rd_stb
    output logic [31:0] irq_en_ff, // Current enable register
    output logic irq_ff // Interrupt request, active high level
);

    // ------------------------------------------------------------
    // Bus supply sense crossing and change detection
    // ------------------------------------------------------------
    logic supply_sync;
    logic supply_prev_ff;
    logic nxt_supply_prev;
    logic supply_change;

    uie_sync u_supply_sync (
        .clock(clock),
        .rstn(rstn),
        .d(bus_supply_pin),
        .q(supply_sync)
    );

    // Either edge of the supply level is an event
    always_comb begin
        nxt_supply_prev = supply_sync;
        supply_change = supply_sync ^ supply_prev_ff;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            supply_prev_ff <= 1'b0;
        end else begin
            supply_prev_ff <= nxt_supply_prev;
        end
    end

    // ------------------------------------------------------------
    // Event vector in register bit order
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] src_evt;

    always_comb begin
        src_evt = '0;
        for (int i = 0; i < NUM_DATA_EP; i++) begin
            src_evt[BIT_EP_LO + 2 * i] = ep_rx_evt[i];
            src_evt[BIT_EP_LO + 2 * i + 1] = ep_tx_evt[i];
        end
        src_evt[BIT_CTRL_IN] = ctrl_in_evt;
        src_evt[BIT_CTRL_OUT] = ctrl_out_evt;
        src_evt[BIT_SETUP] = ctrl_setup_evt;
        src_evt[BIT_VBUS] = supply_change;
        src_evt[BIT_DMA] = dma_change_evt;
        src_evt[BIT_SPEED] = speed_change_evt;
        src_evt[BIT_RESUME] = resume_evt;
        src_evt[BIT_SUSPEND] = suspend_evt;
        src_evt[BIT_PSOF] = pseudo_frame_evt;
        src_evt[BIT_SOF] = frame_start_evt;
        src_evt[BIT_BRST] = bus_reset_evt;
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic wr_enable;
    logic rd_enable;
    logic rd_pending;

    always_comb begin
        wr_enable = wr_stb && (addr == OFS_ENABLE);
        rd_enable = rd_stb && (addr == OFS_ENABLE);
        rd_pending = rd_stb && (addr == OFS_PENDING);
    end

    // ------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------
    // Reserved position has no flag so it always reads zero
    logic [NUM_SRC-1:0] pend_q;
    logic [31:0] pending_word;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : gen_pend
            if (g == BIT_RSVD) begin : gen_rsvd
                assign pend_q[g] = 1'b0;
            end else begin : gen_flag
                uie_sticky u_flag (
                    .clock(clock),
                    .rstn(rstn),
                    .set(src_evt[g]),
                    .clr(rd_pending),
                    .q(pend_q[g])
                );
            end
        end
    endgenerate

    assign pending_word = {{(32 - NUM_SRC){1'b0}}, pend_q};

    // ------------------------------------------------------------
    // Enable register
    // ------------------------------------------------------------
    logic [31:0] nxt_irq_en;

    // Reserved bits are not stored; a careless write cannot set them
    always_comb begin
        nxt_irq_en = irq_en_ff;
        if (wr_enable) begin
            nxt_irq_en = wdata & WRITE_MASK;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_en_ff <= ENABLE_RST;
        end else begin
            irq_en_ff <= nxt_irq_en;
        end
    end

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] nxt_pend;
    logic nxt_irq;

    // Built from next values so the output tracks the flops with no lag
    always_comb begin
        nxt_pend = rd_pending ? '0 : pend_q;
        nxt_pend = nxt_pend | src_evt;
        nxt_pend[BIT_RSVD] = 1'b0;
        nxt_irq = |(nxt_pend & nxt_irq_en[NUM_SRC-1:0]);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] nxt_rd_data;

    // Unmapped addresses and idle cycles return zero
    always_comb begin
        nxt_rd_data = ZERO_WORD;
        if (rd_enable) begin
            nxt_rd_data = irq_en_ff;
        end else if (rd_pending) begin
            nxt_rd_data = pending_word;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_data_ff <= ZERO_WORD;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking

    default disable iff (!rstn);

    chk_ep_enable_store: assert property (
        wr_enable |=> irq_en_ff[BIT_EP_HI:BIT_EP_LO] == $past(wdata[BIT_EP_HI:BIT_EP_LO]))
    else $error("endpoint enable bits not stored");

    chk_ep_tx_order: assert property (
        ep_tx_evt[0] && !ep_rx_evt[0] && !pend_q[BIT_EP_LO] |=> pend_q[BIT_EP_LO + 1] && !pend_q[BIT_EP_LO])
    else $error("endpoint one transmit event not pending");

    chk_ctrl_in_gate: assert property (
        ctrl_in_evt && irq_en_ff[BIT_CTRL_IN] && !wr_stb |=> irq_ff)
    else $error("control IN event did not raise request");

    chk_ctrl_out_gate: assert property (
        ctrl_out_evt && irq_en_ff[BIT_CTRL_OUT] && !wr_stb |-> ##1 irq_ff && pend_q[BIT_CTRL_OUT])
    else $error("control OUT event did not raise request");

    chk_setup_pending: assert property (
        ctrl_setup_evt |=> pend_q[BIT_SETUP])
    else $error("setup event not pending");

    chk_supply_change: assert property (
        $changed(bus_supply_pin) |-> ##3 pend_q[BIT_VBUS])
    else $error("supply change not pending after three cycles");

    chk_dma_speed_flags: assert property (
        (dma_change_evt |=> pend_q[BIT_DMA]) and (speed_change_evt |=> pend_q[BIT_SPEED]))
    else $error("DMA or speed change not pending");

    chk_bus_events: assert property (
        (resume_evt |=> pend_q[BIT_RESUME]) and (suspend_evt |=> pend_q[BIT_SUSPEND]) and
            (pseudo_frame_evt |=> pend_q[BIT_PSOF]) and (frame_start_evt |=> pend_q[BIT_SOF]))
    else $error("bus event not pending");

    chk_enable_reset: assert property (
        @(posedge clock) disable iff (1'b0) !rstn |-> irq_en_ff == ENABLE_RST)
    else $error("enable register not at reset value");

    chk_reserved_zero: assert property (
        (irq_en_ff & ~WRITE_MASK) == ZERO_WORD && !pend_q[BIT_RSVD])
    else $error("reserved bit became set");

    chk_irq_level_match: assert property (
        irq_ff == |(pend_q & irq_en_ff[NUM_SRC-1:0]))
    else $error("request does not match pending and enabled bits");

    chk_mask_keeps_pending: assert property (
        wr_stb |=> (pend_q & $past(pend_q)) == $past(pend_q))
    else $error("enable write discarded a pending flag");

    chk_read_clears: assert property (
        rd_pending |=> rd_data_ff == $past(pending_word) && (pend_q & ~$past(src_evt)) == '0)
    else $error("status read wrong or not cleared");

    // One pair of map checks per data endpoint
    for (g = 0; g < NUM_DATA_EP; g++) begin : gen_ep_chk
        chk_ep_rx_map: assert property (
            ep_rx_evt[g] |=> pend_q[BIT_EP_LO + 2 * g])
        else $error("endpoint receive event not pending");

        chk_ep_tx_map: assert property (
            ep_tx_evt[g] |=> pend_q[BIT_EP_LO + 2 * g + 1])
        else $error("endpoint transmit event not pending");
    end

    // A write may open a mask in the same cycle, so writes are left out here
    chk_masked_no_irq: assert property (
        !wr_stb && ((pend_q | src_evt) & irq_en_ff[NUM_SRC-1:0]) == '0 |=> !irq_ff)
    else $error("masked source raised request");

    // Any enabled event in a cycle with no write strobe must reach the request one cycle later
    chk_enabled_event_irq: assert property (
        (src_evt & irq_en_ff[NUM_SRC-1:0]) != '0 && !wr_stb |=> irq_ff)
    else $error("enabled event did not raise request");

    chk_setup_irq: assert property (
        ctrl_setup_evt && irq_en_ff[BIT_SETUP] && !wr_stb |=> irq_ff)
    else $error("setup event did not raise request");

    chk_bus_reset_irq: assert property (
        bus_reset_evt && irq_en_ff[BIT_BRST] && !wr_stb |=> irq_ff && pend_q[BIT_BRST])
    else $error("bus reset event did not raise request");

    chk_supply_flag: assert property (
        supply_change |=> pend_q[BIT_VBUS])
    else $error("supply edge not pending");

    chk_read_drops_irq: assert property (
        rd_pending && src_evt == '0 |=> !irq_ff && pend_q == '0)
    else $error("request stayed up after status read");

    chk_pending_hold: assert property (
        !rd_pending && src_evt == '0 |=> pend_q == $past(pend_q))
    else $error("pending flag changed with no event or read");

    // Watched without the disable so that reset itself is checked
    chk_reset_clear: assert property (
        @(posedge clock) disable iff (1'b0) !rstn |-> pend_q == '0 && !irq_ff && rd_data_ff == ZERO_WORD)
    else $error("pending or request not cleared by reset");

    // ------------------------------------------------------------
    // Register and read path checks
    // ------------------------------------------------------------
    chk_enable_write: assert property (
        wr_enable |=> irq_en_ff == ($past(wdata) & WRITE_MASK))
    else $error("enable write not stored");

    chk_enable_hold: assert property (
        !wr_enable |=> irq_en_ff == $past(irq_en_ff))
    else $error("enable register changed without a write");

    chk_enable_read: assert property (
        rd_enable |=> rd_data_ff == $past(irq_en_ff))
    else $error("enable read returned wrong data");

    // Read data must not linger, or software could mistake it for a fresh read
    chk_read_idle: assert property (
        !rd_stb |=> rd_data_ff == ZERO_WORD)
    else $error("read data not zero outside a read");

    chk_unmapped_read: assert property (
        rd_stb && !rd_enable && !rd_pending |=> rd_data_ff == ZERO_WORD)
    else $error("unmapped read returned data");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    cov_irq_rise: cover property ($rose(irq_ff));
    cov_read_then_irq_drop: cover property (rd_pending ##1 $fell(irq_ff));
    cov_mask_while_pending: cover property (irq_ff && wr_enable ##1 !irq_ff && |pend_q);
    cov_set_during_clear: cover property (rd_pending && |src_evt);
    cov_supply_edge: cover property (supply_change);

endmodule

// File: bench/tb.sv
// Self-checking testbench for the device interrupt enable block
`timescale 1ns/1ps

module tb
    import uie_pkg::*;
;
    logic clock;
    logic rstn;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic [25:0] evt;
    logic bus_supply_pin;
    logic [31:0] rd_data_ff;
    logic [31:0] irq_en_ff;
    logic irq_ff;
    int failures;
    int num_checks;
    int cycle_count;
    logic [31:0] rdv;

    uie_top i_uie_top (
        .clock(clock),
        .rstn(rstn),
        .addr(addr),
        .wdata(wdata),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .ep_tx_evt({evt[25], evt[23], evt[21], evt[19], evt[17], evt[15], evt[13]}),
        .ep_rx_evt({evt[24], evt[22], evt[20], evt[18], evt[16], evt[14], evt[12]}),
        .ctrl_in_evt(evt[11]),
        .ctrl_out_evt(evt[10]),
        .ctrl_setup_evt(evt[8]),
        .bus_supply_pin(bus_supply_pin),
        .dma_change_evt(evt[6]),
        .speed_change_evt(evt[5]),
        .resume_evt(evt[4]),
        .suspend_evt(evt[3]),
        .pseudo_frame_evt(evt[2]),
        .frame_start_evt(evt[1]),
        .bus_reset_evt(evt[0]),
        .rd_data_ff(rd_data_ff),
        .irq_en_ff(irq_en_ff),
        .irq_ff(irq_ff)
    );

    // ------------------------------------------------------------
    // Clock, reset and hang guard
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 5000) begin
            failures = failures + 1;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1;
        d = rd_data_ff;
    endtask

    task automatic fire(input int b);
        @(posedge clock);
        evt[b] <= 1'b1;
        @(posedge clock);
        evt <= 26'h0;
        #1;
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset_values();
        check("enable port", irq_en_ff, ENABLE_RST);
        rd(OFS_ENABLE, rdv);
        check("enable read", rdv, 32'h0000_0001);
        @(posedge clock);
        #1;
        check("read data idle", rd_data_ff, ZERO_WORD);
        check("irq idle", {31'h0, irq_ff}, ZERO_WORD);
        $display("test reset values done");
    endtask

    task automatic test_reserved_and_map();
        wr(OFS_ENABLE, 32'h03ff_fdff);
        check("enable all", irq_en_ff, 32'h03ff_fdff);
        rd(OFS_ENABLE, rdv);
        check("enable all read", rdv, 32'h03ff_fdff);
        wr(12'h100, 32'h0000_0000);
        check("unmapped write", irq_en_ff, 32'h03ff_fdff);
        rd(12'h000, rdv);
        check("unmapped read", rdv, ZERO_WORD);
        wr(OFS_PENDING, 32'hffff_ffff);
        rd(OFS_PENDING, rdv);
        check("pending read only", rdv, ZERO_WORD);
        $display("test reserved and map done");
    endtask

    // Every source but bus supply sense: masked event is held pending, unmasking raises the request
    task automatic test_each_source();
        logic [31:0] one;
        for (int b = 0; b < NUM_SRC; b++) begin
            if (b == BIT_RSVD || b == BIT_VBUS) begin
                continue;
            end
            one = 32'h1 << b;
            wr(OFS_ENABLE, WRITE_MASK & ~one);
            fire(b);
            check($sformatf("masked irq bit %0d", b), {31'h0, irq_ff}, ZERO_WORD);
            wr(OFS_ENABLE, one);
            check($sformatf("irq bit %0d", b), {31'h0, irq_ff}, 32'h1);
            rd(OFS_PENDING, rdv);
            check($sformatf("pending bit %0d", b), rdv, one);
            check($sformatf("irq clear %0d", b), {31'h0, irq_ff}, ZERO_WORD);
        end
        $display("test each source done");
    endtask

    // Supply level crosses a synchroniser; both edges are events
    task automatic test_supply_sense();
        wr(OFS_ENABLE, 32'h0000_0080);
        for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            bus_supply_pin <= (k == 0);
            repeat (5) @(posedge clock);
            #1;
            check("supply irq", {31'h0, irq_ff}, 32'h1);
            rd(OFS_PENDING, rdv);
            check("supply pending", rdv, 32'h0000_0080);
        end
        $display("test supply sense done");
    endtask

    // An event in the clearing cycle survives the status read
    task automatic test_set_during_clear();
        wr(OFS_ENABLE, 32'h0000_0010);
        fire(BIT_RESUME);
        @(posedge clock);
        addr <= OFS_PENDING;
        rd_stb <= 1'b1;
        evt[BIT_RESUME] <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        evt <= 26'h0;
        #1;
        check("read during event", rd_data_ff, 32'h0000_0010);
        check("irq kept", {31'h0, irq_ff}, 32'h1);
        rd(OFS_PENDING, rdv);
        check("event kept", rdv, 32'h0000_0010);
        check("irq after second read", {31'h0, irq_ff}, ZERO_WORD);
        $display("test set during clear done");
    endtask

    // Reset in mid run restores the enables and drops every pending flag
    task automatic test_mid_reset();
        wr(OFS_ENABLE, WRITE_MASK);
        fire(BIT_SUSPEND);
        check("irq before reset", {31'h0, irq_ff}, 32'h1);
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        #1;
        check("enable after reset", irq_en_ff, 32'h0000_0001);
        check("irq after reset", {31'h0, irq_ff}, ZERO_WORD);
        rd(OFS_PENDING, rdv);
        check("pending after reset", rdv, ZERO_WORD);
        $display("test mid reset done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b1;
        addr = 12'h000;
        wdata = 32'h0000_0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        evt = 26'h0;
        bus_supply_pin = 1'b0;
        failures = 0;
        num_checks = 0;
        // Reset falls just after time zero so every flop sees the edge
        #1;
        rstn = 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        #1;
        test_reset_values();
        test_reserved_and_map();
        test_each_source();
        test_supply_sense();
        test_set_during_clear();
        test_mid_reset();
        final_report();
    end
endmodule
